// file: fls_pkg.sv
// ============================================================
// slice constants and carriers
package fls_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_LUT_F = 8'h00;
   localparam logic [7:0] OFS_LUT_G = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // field positions and reset values
   localparam int CTRL_GINIT_BIT = 0;
   localparam int LUT_MSB = 15;
   localparam logic [15:0] LUT_RESET = 16'h0000;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [31:0] CFG_WMASK = 32'h000fffff;
   localparam logic Q_RESET = 1'b0;
   // bus encodings
   localparam logic HRESP_OKAY = 1'b0;
   localparam int HTRANS_ACTIVE_BIT = 1;

   typedef enum logic [1:0] {LUT_LOGIC, LUT_RAM_S, LUT_RAM_D, LUT_SHIFT} fls_lut_mode_type;

   typedef struct packed {
      logic [11:0] rsvd;
      logic [1:0] dsel;
      logic inv_by;
      logic inv_sr;
      logic inv_ce;
      logic inv_clk;
      logic ce_used;
      logic init_follow;
      logic [1:0] init;
      logic [1:0] force_high;
      logic by_en;
      logic sr_en;
      logic sync_sr;
      logic latch;
      fls_lut_mode_type mode_g;
      fls_lut_mode_type mode_f;
   } fls_cfg_type;

   typedef struct packed {
      logic [23:0] rsvd;
      logic clk_level;
      logic shift_out;
      logic fx;
      logic f5;
      logic upper;
      logic lower;
      logic [1:0] q;
   } fls_status_type;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } fls_ahb_req_type;
endpackage

// file: fls_slice.sv
// How it works
// - two 4-input generators, two storage elements, combiners
// - any 4-input function, same read path
// - generator is logic, RAM or shift register
// - generator output feeds slice output and storage
// - five-input combiner merges generators, wide combiner merges neighbour inputs
// - storage is flip-flop or latch
// - storage data from generator or bypass input
// - clock enable active high, unused means asserted
// - force-state sets one or zero per attribute
// - upper bypass forces opposite; reset wins
// - init value follows attribute or set apart
// - set/reset synchronous or asynchronous, none/set/reset/both
// - reset beats set, clear beats preset
// - shared controls, each with own polarity
// - each generator is 16x1 RAM, synchronous write
// - RAMs combine into wider or deeper arrays
// - RAM read combinational, storage gives registered read
// - RAM write enable active high from force-state
// - dual-port 16x1 uses both generators
// - block of four slices, chains between them
// - dual-port: write port plus separate read port
// - modes ending S single-port, D dual-port
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module fls_slice (
   // system
   input wire logic clock,
   input wire logic srst,
   input wire logic clken,
   // register bus
   input wire fls_pkg::fls_ahb_req_type ahb,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // slice inputs
   input wire logic [3:0] f_in,
   input wire logic [3:0] g_in,
   input wire logic bypass_in_lower,
   input wire logic bypass_in_upper,
   input wire logic force_state_input,
   input wire logic slice_clk,
   input wire logic slice_ce,
   input wire logic [1:0] fx_in,
   // slice outputs
   output logic out_lower,
   output logic out_upper,
   output logic q_lower,
   output logic q_upper,
   output logic f5_out,
   output logic fx_out,
   output logic shift_out
);
   import fls_pkg::*;

   // ============================================================
   // bus slave
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_addr;
   fls_cfg_type cfg;
   fls_status_type status;
   logic [31:0] rd_word;
   logic [15:0] lut [2];
   logic q_r [2];

   wire addr_take = ahb.hsel & hready & ahb.htrans[HTRANS_ACTIVE_BIT];
   wire wr_now = clken & dp_valid & dp_write;
   wire wr_lut_f = wr_now & (dp_addr == OFS_LUT_F);
   wire wr_lut_g = wr_now & (dp_addr == OFS_LUT_G);
   wire wr_cfg = wr_now & (dp_addr == OFS_CONFIG);
   wire wr_ctrl = wr_now & (dp_addr == OFS_CONTROL);
   wire ginit = wr_ctrl & ahb.hwdata[CTRL_GINIT_BIT];
   wire [1:0] bus_wr = {wr_lut_g, wr_lut_f};

   assign hreadyout = clken;
   assign hresp = HRESP_OKAY;

   always_ff @(posedge clock) begin
      if (srst) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else if (clken && hready) begin
         dp_valid <= addr_take;
         dp_write <= ahb.hwrite;
         dp_addr <= ahb.haddr[7:0];
      end
   end

   always_comb begin
      rd_word = 32'h00000000;
      if (ahb.haddr[7:0] == OFS_LUT_F) begin
         rd_word = {16'h0000, lut[0]};
      end else if (ahb.haddr[7:0] == OFS_LUT_G) begin
         rd_word = {16'h0000, lut[1]};
      end else if (ahb.haddr[7:0] == OFS_CONFIG) begin
         rd_word = cfg;
      end else if (ahb.haddr[7:0] == OFS_STATUS) begin
         rd_word = status;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         hrdata <= 32'h00000000;
      end else if (clken && addr_take && !ahb.hwrite) begin
         hrdata <= rd_word;
      end
   end

   // configuration, reserved bits kept at zero
   always_ff @(posedge clock) begin
      if (srst) begin
         cfg <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= ahb.hwdata & CFG_WMASK;
      end
   end

   // ============================================================
   // shared slice controls
   logic clk_prev;
   wire clk_act = slice_clk ^ cfg.inv_clk;
   wire clk_edge = clk_act & ~clk_prev;
   wire ce_eff = ~cfg.ce_used | (slice_ce ^ cfg.inv_ce);
   wire sr_act = cfg.sr_en & (force_state_input ^ cfg.inv_sr);
   wire by_act = cfg.sr_en & cfg.by_en & (bypass_in_upper ^ cfg.inv_by);
   wire ram_we = force_state_input ^ cfg.inv_sr;
   wire ram_tick = clk_edge & ce_eff & ram_we;
   wire shift_tick = clk_edge & ce_eff;

   always_ff @(posedge clock) begin
      if (srst) begin
         clk_prev <= 1'b0;
      end else if (clken) begin
         clk_prev <= clk_act;
      end
   end

   // ============================================================
   // function generators and storage elements
   fls_lut_mode_type mode [2];
   logic [15:0] next_lut [2];
   logic next_q [2];
   wire [3:0] rd_addr [2];
   wire [3:0] wr_addr [2];
   wire [1:0] data_in;
   wire [1:0] shift_in;
   wire [1:0] bypass = {bypass_in_upper, bypass_in_lower};
   wire [1:0] lut_out;
   wire [1:0] d_v;
   wire [1:0] set_v;
   wire [1:0] rst_v;
   wire [1:0] init_v;
   wire [1:0] capture;

   assign mode[0] = cfg.mode_f;
   assign mode[1] = cfg.mode_g;
   assign rd_addr[0] = f_in;
   assign rd_addr[1] = g_in;
   assign wr_addr[0] = f_in;
   assign wr_addr[1] = (cfg.mode_g == LUT_RAM_D) ? f_in : g_in;
   assign data_in[0] = bypass_in_lower;
   assign data_in[1] = (cfg.mode_g == LUT_RAM_D) ? bypass_in_lower : bypass_in_upper;
   assign shift_in[0] = bypass_in_lower;
   // generators chain when both shift
   assign shift_in[1] = (cfg.mode_f == LUT_SHIFT) ? lut[0][LUT_MSB] : bypass_in_upper;

   for (genvar i = 0; i < 2; i++) begin : g_elem
      // one read path for every mode and function
      assign lut_out[i] = lut[i][rd_addr[i]];
      assign d_v[i] = cfg.dsel[i] ? bypass[i] : lut_out[i];
      assign set_v[i] = (sr_act & cfg.force_high[i]) | (by_act & ~cfg.force_high[i]);
      assign rst_v[i] = (sr_act & ~cfg.force_high[i]) | (by_act & cfg.force_high[i]);
      assign init_v[i] = cfg.init_follow ? cfg.force_high[i] : cfg.init[i];
      assign capture[i] = ce_eff & (cfg.latch ? clk_act : clk_edge);

      always_comb begin
         next_lut[i] = lut[i];
         if (bus_wr[i]) begin
            next_lut[i] = ahb.hwdata[15:0];
         end else if ((mode[i] == LUT_RAM_S || mode[i] == LUT_RAM_D) && ram_tick) begin
            next_lut[i][wr_addr[i]] = data_in[i];
         end else if (mode[i] == LUT_SHIFT && shift_tick) begin
            next_lut[i] = {lut[i][14:0], shift_in[i]};
         end
      end

      always_comb begin
         next_q[i] = q_r[i];
         if (ginit) begin
            next_q[i] = init_v[i];
         end else if (!cfg.sync_sr && rst_v[i]) begin
            next_q[i] = 1'b0;
         end else if (!cfg.sync_sr && set_v[i]) begin
            next_q[i] = 1'b1;
         end else if (capture[i]) begin
            if (cfg.sync_sr && rst_v[i]) begin
               next_q[i] = 1'b0;
            end else if (cfg.sync_sr && set_v[i]) begin
               next_q[i] = 1'b1;
            end else begin
               next_q[i] = d_v[i];
            end
         end
      end

      always_ff @(posedge clock) begin
         if (srst) begin
            lut[i] <= LUT_RESET;
         end else if (clken) begin
            lut[i] <= next_lut[i];
         end
      end

      always_ff @(posedge clock) begin
         if (srst) begin
            q_r[i] <= Q_RESET;
         end else if (clken) begin
            q_r[i] <= next_q[i];
         end
      end
   end

   // ============================================================
   // combiners and outputs
   assign out_lower = lut_out[0];
   assign out_upper = lut_out[1];
   // lower bypass picks a generator: five-input function or 32-deep RAM
   assign f5_out = bypass_in_lower ? lut_out[0] : lut_out[1];
   // neighbour slices feed the wide combiner across the block
   assign fx_out = bypass_in_upper ? fx_in[1] : fx_in[0];
   assign shift_out = lut[1][LUT_MSB];
   assign q_lower = q_r[0];
   assign q_upper = q_r[1];

   always_comb begin
      status = '0;
      status.q = {q_r[1], q_r[0]};
      status.lower = lut_out[0];
      status.upper = lut_out[1];
      status.f5 = f5_out;
      status.fx = fx_out;
      status.shift_out = shift_out;
      status.clk_level = clk_act;
   end

   // ============================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   wire f_is_ram = (cfg.mode_f == LUT_RAM_S) || (cfg.mode_f == LUT_RAM_D);

   a_ram_write_lands: assert property (
      clken && f_is_ram && ram_tick && !wr_lut_f
      |=> lut[0][$past(f_in)] == $past(bypass_in_lower))
      else $error("ram write not stored");

   a_dual_port_mirror: assert property (
      clken && cfg.mode_g == LUT_RAM_D && ram_tick && !wr_lut_g
      |=> lut[1][$past(f_in)] == $past(bypass_in_lower))
      else $error("second port copy not written");

   a_shift_moves: assert property (
      clken && cfg.mode_f == LUT_SHIFT && shift_tick && !wr_lut_f
      |=> lut[0] == {$past(lut[0][14:0]), $past(bypass_in_lower)})
      else $error("shift register did not shift");

   a_reset_beats_set: assert property (
      clken && !ginit && !cfg.sync_sr && rst_v[0]
      |=> q_r[0] == 1'b0)
      else $error("asynchronous clear lost");

   a_force_high_sets: assert property (
      clken && !ginit && !cfg.sync_sr && sr_act && !by_act
      |=> q_r[0] == $past(cfg.force_high[0]))
      else $error("force-state value wrong");

   a_ff_captures_d: assert property (
      clken && !ginit && !cfg.latch && clk_edge && ce_eff && !set_v[0] && !rst_v[0]
      |=> q_r[0] == $past(d_v[0]))
      else $error("flip-flop missed data");

   a_latch_holds: assert property (
      clken && !ginit && cfg.latch && !(clk_act && ce_eff) && !set_v[1] && !rst_v[1]
      |=> $stable(q_r[1]))
      else $error("closed latch changed");

   a_ce_default_on: assert property (
      clken && !ginit && !cfg.ce_used && !cfg.latch && clk_edge && !set_v[1] && !rst_v[1]
      |=> q_r[1] == $past(d_v[1]))
      else $error("unused clock enable blocked capture");

   a_init_load: assert property (
      ginit |=> q_r[0] == $past(init_v[0]) && q_r[1] == $past(init_v[1]))
      else $error("initial value not loaded");

   a_sync_waits_edge: assert property (
      clken && !ginit && cfg.sync_sr && !capture[0]
      |=> $stable(q_r[0]))
      else $error("synchronous storage moved without clock");

   a_sync_reset_wins: assert property (
      clken && !ginit && cfg.sync_sr && capture[1] && rst_v[1]
      |=> q_r[1] == 1'b0)
      else $error("synchronous reset lost to set");

   a_ram_we_gates: assert property (
      clken && f_is_ram && !ram_we && !wr_lut_f
      |=> $stable(lut[0]))
      else $error("ram written with write enable low");
endmodule // fls_slice

// file: fls_fabric.sv
`timescale 1ns/1ps
// ============================================================
// fabric side: pulses the slice clock on request
module fls_fabric (
   // system
   input wire logic clock,
   input wire logic srst,
   // request
   input wire logic tick,
   // slice side
   output logic slice_clk
);
   // one-cycle high pulse, idle low between pulses
   always_ff @(posedge clock) begin
      if (srst)
         slice_clk <= 1'b0;
      else
         slice_clk <= tick & ~slice_clk;
   end
endmodule // fls_fabric

// file: fls_slice_tb.sv
`timescale 1ns/1ps
// ============================================================
// slice testbench
module fls_slice_tb;
   import fls_pkg::*;
   logic clock, srst, clken, hready, hreadyout, hresp, tick, force_state_input, slice_ce;
   logic bypass_in_lower, bypass_in_upper, slice_clk, out_lower, out_upper, q_lower, q_upper;
   logic f5_out, fx_out, shift_out;
   logic [1:0] fx_in;
   logic [3:0] f_in, g_in;
   logic [31:0] hrdata, rd;
   logic [15:0] lf = 16'hc3a5;
   logic [15:0] lg = 16'h5a3c;
   logic [7:0] adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
   fls_ahb_req_type ahb;
   int n_mismatch, compares;
   assign hready = hreadyout;
   fls_slice fls_slice_inst (.clock(clock), .srst(srst), .clken(clken), .ahb(ahb),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .f_in(f_in),
      .g_in(g_in), .bypass_in_lower(bypass_in_lower), .bypass_in_upper(bypass_in_upper),
      .force_state_input(force_state_input), .slice_clk(slice_clk), .slice_ce(slice_ce),
      .fx_in(fx_in), .out_lower(out_lower), .out_upper(out_upper), .q_lower(q_lower),
      .q_upper(q_upper), .f5_out(f5_out), .fx_out(fx_out), .shift_out(shift_out));
   fls_fabric fls_fabric_inst (.clock(clock), .srst(srst), .tick(tick), .slice_clk(slice_clk));
   // ============================================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      ahb <= '{1'b1, {24'h000000, a}, 2'b10, wr, 3'b010, ahb.hwdata};
      do @(posedge clock); while (hready !== 1'b1);
      ahb.htrans <= 2'b00;
      ahb.hsel <= 1'b0;
      ahb.hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(rd, exp);
      chk(hresp, HRESP_OKAY);
   endtask
   // m = fx_in, force, upper bypass, lower bypass
   task automatic drv(input logic [3:0] f, input logic [3:0] g, input logic [4:0] m);
      @(posedge clock);
      f_in <= f;
      g_in <= g;
      {fx_in, force_state_input, bypass_in_upper, bypass_in_lower} <= m;
      @(negedge clock);
   endtask
   task automatic pulse;
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ============================================================
   // clock, watchdog, tests
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (6000) @(posedge clock);
      n_mismatch++;
      results();
   end
   initial begin
      {srst, clken, tick, ahb, f_in, g_in, fx_in, slice_ce} = '0;
      {force_state_input, bypass_in_upper, bypass_in_lower, n_mismatch, compares} = '0;
      srst = 1'b1;
      clken = 1'b1;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) rdk(adr[i], 32'h00000000);
      bus(1'b1, OFS_CONFIG, 32'hffffffff);
      rdk(OFS_CONFIG, CFG_WMASK);
      bus(1'b1, OFS_STATUS, 32'hffffffff);
      bus(1'b1, 8'h14, 32'hffffffff);
      rdk(OFS_STATUS, 32'h00000080);
      rdk(8'h14, 32'h00000000);
      bus(1'b1, OFS_CONFIG, 32'h00000000);
      bus(1'b1, OFS_LUT_F, {16'h0000, lf});
      bus(1'b1, OFS_LUT_G, {16'h0000, lg});
      rdk(OFS_LUT_F, {16'h0000, lf});
      for (int i = 0; i < 16; i++) begin
         drv(i[3:0], 4'(15 - i), {i[1:0], 1'b0, i[3], i[0]});
         chk(out_lower, lf[i]);
         chk(out_upper, lg[15 - i]);
         chk(f5_out, i[0] ? lf[i] : lg[15 - i]);
         chk(fx_out, i[3] ? i[1] : i[0]);
      end
      // flip-flop capture only at slice clock edge
      drv(4'h0, 4'h2, 5'b00000);
      pulse();
      chk({q_upper, q_lower}, 2'b11);
      drv(4'h1, 4'h0, 5'b00000);
      repeat (4) @(posedge clock);
      chk({q_upper, q_lower}, 2'b11);
      pulse();
      chk({q_upper, q_lower}, 2'b00);
      bus(1'b1, OFS_CONFIG, 32'h000c0000);
      drv(4'h0, 4'h2, 5'b00001);
      pulse();
      chk({q_upper, q_lower}, 2'b01);
      bus(1'b1, OFS_CONFIG, 32'h00002000);
      drv(4'h0, 4'h2, 5'b00000);
      pulse();
      chk({q_upper, q_lower}, 2'b01);
      @(posedge clock) slice_ce <= 1'b1;
      pulse();
      chk({q_upper, q_lower}, 2'b11);
      bus(1'b1, OFS_CONFIG, 32'h0000a000);
      drv(4'h1, 4'h0, 5'b00000);
      pulse();
      chk({q_upper, q_lower}, 2'b11);
      bus(1'b1, OFS_CONFIG, 32'h00004000);
      pulse();
      chk({q_upper, q_lower}, 2'b00);
      // force-state, opposite force, sync and async
      bus(1'b1, OFS_CONFIG, 32'h00000160);
      drv(4'h1, 4'h0, 5'b00100);
      repeat (3) @(posedge clock);
      chk({q_upper, q_lower}, 2'b00);
      pulse();
      chk({q_upper, q_lower}, 2'b01);
      bus(1'b1, OFS_CONFIG, 32'h000001e0);
      drv(4'h1, 4'h0, 5'b00110);
      pulse();
      chk({q_upper, q_lower}, 2'b00);
      bus(1'b1, OFS_CONFIG, 32'h00000140);
      drv(4'h1, 4'h0, 5'b00100);
      repeat (3) @(posedge clock);
      chk({q_upper, q_lower}, 2'b01);
      // init values, apart and following the force attribute
      drv(4'h1, 4'h0, 5'b00000);
      bus(1'b1, OFS_CONFIG, 32'h00000800);
      bus(1'b1, OFS_CONTROL, 32'h00000001);
      @(negedge clock);
      chk({q_upper, q_lower}, 2'b10);
      rdk(OFS_CONTROL, 32'h00000000);
      bus(1'b1, OFS_CONFIG, 32'h00001100);
      bus(1'b1, OFS_CONTROL, 32'h00000001);
      @(negedge clock);
      chk({q_upper, q_lower}, 2'b01);
      // single-port RAM on F
      bus(1'b1, OFS_CONFIG, 32'h00000001);
      bus(1'b1, OFS_LUT_F, 32'h00000000);
      drv(4'h4, 4'h0, 5'b00001);
      pulse();
      drv(4'h5, 4'h0, 5'b00101);
      pulse();
      drv(4'h5, 4'h0, 5'b00000);
      chk(out_lower, 1'b1);
      drv(4'h4, 4'h0, 5'b00000);
      chk(out_lower, 1'b0);
      // dual-port RAM on G
      bus(1'b1, OFS_CONFIG, 32'h00000008);
      bus(1'b1, OFS_LUT_G, 32'h00000000);
      drv(4'h3, 4'h0, 5'b00101);
      pulse();
      drv(4'h0, 4'h3, 5'b00000);
      chk(out_upper, 1'b1);
      drv(4'h3, 4'h0, 5'b00000);
      chk(out_upper, 1'b0);
      // shift register on F
      bus(1'b1, OFS_CONFIG, 32'h00000003);
      bus(1'b1, OFS_LUT_F, 32'h00000000);
      drv(4'h0, 4'h0, 5'b00001);
      pulse();
      drv(4'h0, 4'h0, 5'b00000);
      pulse();
      chk(out_lower, 1'b0);
      drv(4'h1, 4'h0, 5'b00000);
      chk(out_lower, 1'b1);
      // shift chain from F into G and out of the slice
      bus(1'b1, OFS_CONFIG, 32'h0000000f);
      bus(1'b1, OFS_LUT_F, 32'h00008000);
      bus(1'b1, OFS_LUT_G, 32'h00004000);
      @(negedge clock);
      chk(shift_out, 1'b0);
      pulse();
      chk(shift_out, 1'b1);
      chk(out_upper, 1'b1);
      // latch: transparent while the active clock level stands
      bus(1'b1, OFS_CONFIG, 32'h000c4010);
      drv(4'h0, 4'h0, 5'b00011);
      @(negedge clock);
      chk({q_upper, q_lower}, 2'b11);
      drv(4'h0, 4'h0, 5'b00010);
      @(negedge clock);
      chk({q_upper, q_lower}, 2'b10);
      bus(1'b1, OFS_CONFIG, 32'h000c0010);
      drv(4'h0, 4'h0, 5'b00001);
      repeat (3) @(negedge clock);
      chk({q_upper, q_lower}, 2'b10);
      pulse();
      chk({q_upper, q_lower}, 2'b01);
      results();
   end
endmodule // fls_slice_tb
